// ---- rtl/tlv_irq_unit.sv ----
// Two-level vectored interrupt unit: flags, enables, ranking, vectors
`timescale 1ns/100ps
// Operation
// - Global enable off blocks every request
// - Per-source enable bits in enable register
// - Fixed vector per source, reset at zero
// - Falling edge raises request in edge mode
// - Low pin level raises request in level mode
// - Hardware sets external flags in timer control
// - Edge external flag cleared when vectored
// - Timer rollover requests, except timer 0 mode 3
// - Timer 0/1 flags cleared on service
// - Timer 2 rollover or trigger share vector
// - Timer 2 flags never cleared by hardware
// - Software writes flags like hardware does
// - Serial flags share vector, software clears
// - Accept sets in-service, then jumps to vector
// - Return clears in-service flag of level
// - Enable register resets to all zero
// - Single-bit writes leave other bits alone
// - Equal level served in fixed natural order
// - Priority bit lifts source above clear ones
module tlv_irq_unit
  import tlv_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wdata,
  output logic [7:0] sfr_rdata,
  // External request pins
  input wire logic ext_request_pin0,
  input wire logic ext_request_pin1,
  // Peripheral events
  input wire logic timer0_rollover,
  input wire logic timer0_mode3,
  input wire logic timer1_rollover,
  input wire logic timer2_rollover,
  input wire logic timer2_trigger,
  input wire logic serial_rx_done,
  input wire logic serial_tx_done,
  // Processor core
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic in_service_hi,
  output logic in_service_lo
);
  logic [7:0] ien_q, ien_d;
  logic [7:0] prio_q, prio_d;
  logic [7:0] tctl_q, tctl_d;
  logic [7:0] ser_q, ser_d;
  logic [7:0] t2_q, t2_d;
  logic [7:0] rdata_q, rdata_d;
  tlv_state_e state_q, state_d;
  logic req_q, req_d;
  logic [15:0] vec_q, vec_d;
  logic [2:0] src_q, src_d;
  logic src_hi_q, src_hi_d;
  logic ins_hi_q, ins_hi_d;
  logic ins_lo_q, ins_lo_d;
  logic [1:0] ext_set;
  logic [TLV_NSRC-1:0] src_flag;
  logic [TLV_NSRC-1:0] pend;
  logic [TLV_NSRC-1:0] svc;
  logic sel_valid;
  logic [2:0] sel_idx;
  logic sel_hi;
  logic take;

  // Byte write or single-bit write at a register's address
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] base,
                                     input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    if (sfr_wr && sfr_addr == base) begin
      v = sfr_wdata;
    end
    if (bit_wr && {bit_addr[7:3], 3'h0} == base) begin
      v[bit_addr[2:0]] = bit_wdata;
    end
    return v & mask;
  endfunction

  tlv_ext_detect u_ext0 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ext_request_pin0),
    .edge_select(tctl_q[TLV_TC_IT0]),
    .set(ext_set[0])
  );

  tlv_ext_detect u_ext1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin(ext_request_pin1),
    .edge_select(tctl_q[TLV_TC_IT1]),
    .set(ext_set[1])
  );

  // Gated request per source, natural order index
  always_comb begin
    src_flag[TLV_SRC_EXT0] = tctl_q[TLV_TC_IE0];
    src_flag[TLV_SRC_TMR0] = tctl_q[TLV_TC_TF0];
    src_flag[TLV_SRC_EXT1] = tctl_q[TLV_TC_IE1];
    src_flag[TLV_SRC_TMR1] = tctl_q[TLV_TC_TF1];
    src_flag[TLV_SRC_SER] = ser_q[TLV_SER_RX] | ser_q[TLV_SER_TX];
    src_flag[TLV_SRC_TMR2] = t2_q[TLV_T2_TF] | t2_q[TLV_T2_EXF];
    pend = src_flag & ien_q[TLV_NSRC-1:0] & {TLV_NSRC{ien_q[TLV_IEN_GLOBAL]}};
  end

  tlv_prio_arb #(
    .NSRC(TLV_NSRC)
  ) u_arb (
    .pend(pend),
    .prio(prio_q[TLV_NSRC-1:0]),
    .ins_hi(ins_hi_q),
    .ins_lo(ins_lo_q),
    .sel_valid(sel_valid),
    .sel_idx(sel_idx),
    .sel_hi(sel_hi)
  );

  // Core takes the offered vector on ack while the request stands
  assign take = irq_ack & req_q;

  always_comb begin
    svc = '0;
    if (take) begin
      svc[src_q] = 1'b1;
    end
  end

  // Registers and flags; hardware set wins over any clear
  always_comb begin
    ien_d = upd(ien_q, TLV_ADDR_IEN, TLV_IEN_MASK);
    prio_d = upd(prio_q, TLV_ADDR_PRIO, TLV_PRIO_MASK);
    tctl_d = upd(tctl_q, TLV_ADDR_TCTL, TLV_TCTL_MASK);
    ser_d = upd(ser_q, TLV_ADDR_SER, TLV_SER_MASK);
    t2_d = upd(t2_q, TLV_ADDR_T2, TLV_T2_MASK);
    // Level-mode flags survive service; software must clear them
    tctl_d[TLV_TC_IE0] = ext_set[0] |
      (tctl_d[TLV_TC_IE0] & ~(svc[TLV_SRC_EXT0] & tctl_q[TLV_TC_IT0]));
    tctl_d[TLV_TC_IE1] = ext_set[1] |
      (tctl_d[TLV_TC_IE1] & ~(svc[TLV_SRC_EXT1] & tctl_q[TLV_TC_IT1]));
    // Mode 3 borrows timer 0 for other use, so no request then
    tctl_d[TLV_TC_TF0] = (timer0_rollover & ~timer0_mode3) |
      (tctl_d[TLV_TC_TF0] & ~svc[TLV_SRC_TMR0]);
    tctl_d[TLV_TC_TF1] = timer1_rollover |
      (tctl_d[TLV_TC_TF1] & ~svc[TLV_SRC_TMR1]);
    // Shared vectors: software tells the causes apart and clears
    ser_d[TLV_SER_RX] = serial_rx_done | ser_d[TLV_SER_RX];
    ser_d[TLV_SER_TX] = serial_tx_done | ser_d[TLV_SER_TX];
    t2_d[TLV_T2_TF] = timer2_rollover | t2_d[TLV_T2_TF];
    t2_d[TLV_T2_EXF] = timer2_trigger | t2_d[TLV_T2_EXF];
  end

  // Read data lags the address by one clock; unmapped reads zero
  always_comb begin
    case (sfr_addr)
      TLV_ADDR_IEN: rdata_d = ien_q;
      TLV_ADDR_PRIO: rdata_d = prio_q;
      TLV_ADDR_TCTL: rdata_d = tctl_q;
      TLV_ADDR_SER: rdata_d = ser_q;
      TLV_ADDR_T2: rdata_d = t2_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Request handshake and in-service levels
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    vec_d = vec_q;
    src_d = src_q;
    src_hi_d = src_hi_q;
    ins_hi_d = ins_hi_q;
    ins_lo_d = ins_lo_q;
    // Return releases the most recent, i.e. highest, active level
    if (return_from_interrupt) begin
      if (ins_hi_q) begin
        ins_hi_d = 1'b0;
      end else begin
        ins_lo_d = 1'b0;
      end
    end
    case (state_q)
      TLV_ST_IDLE, TLV_ST_REQ: begin
        if (take) begin
          // One dead cycle lets the cleared flag and level settle
          state_d = TLV_ST_TAKEN;
          req_d = 1'b0;
          if (src_hi_q) begin
            ins_hi_d = 1'b1;
          end else begin
            ins_lo_d = 1'b1;
          end
        end else if (sel_valid) begin
          state_d = TLV_ST_REQ;
          req_d = 1'b1;
          src_d = sel_idx;
          src_hi_d = sel_hi;
          vec_d = TLV_VEC_FIRST + {10'h000, sel_idx, 3'h0};
        end else begin
          state_d = TLV_ST_IDLE;
          req_d = 1'b0;
        end
      end
      TLV_ST_TAKEN: begin
        state_d = TLV_ST_IDLE;
        req_d = 1'b0;
      end
      default: begin
        state_d = TLV_ST_IDLE;
        req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ien_q <= TLV_IEN_RST;
      prio_q <= TLV_PRIO_RST;
      tctl_q <= TLV_TCTL_RST;
      ser_q <= 8'h00;
      t2_q <= 8'h00;
      rdata_q <= 8'h00;
      state_q <= TLV_ST_IDLE;
      req_q <= 1'b0;
      vec_q <= TLV_VEC_RESET;
      src_q <= 3'h0;
      src_hi_q <= 1'b0;
      ins_hi_q <= 1'b0;
      ins_lo_q <= 1'b0;
    end else begin
      ien_q <= ien_d;
      prio_q <= prio_d;
      tctl_q <= tctl_d;
      ser_q <= ser_d;
      t2_q <= t2_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      req_q <= req_d;
      vec_q <= vec_d;
      src_q <= src_d;
      src_hi_q <= src_hi_d;
      ins_hi_q <= ins_hi_d;
      ins_lo_q <= ins_lo_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign irq_req = req_q;
  assign irq_vector = vec_q;
  assign in_service_hi = ins_hi_q;
  assign in_service_lo = ins_lo_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_global_gate: assert property (!ien_q[TLV_IEN_GLOBAL] |=> !irq_req)
    else $error("request offered with global enable off");

  a_vector_map: assert property (
    irq_req |-> irq_vector == TLV_VEC_FIRST + {10'h000, src_q, 3'h0}
      && src_q <= TLV_SRC_TMR2)
    else $error("vector does not match source");

  // A fresh offer must name a source that was gated through one cycle before
  a_offer_pending: assert property (
    !irq_req ##1 irq_req |-> (($past(pend) >> src_q) & 6'h01) == 6'h01)
    else $error("offer made for a source that was not pending");

  a_level_set: assert property (
    !tctl_q[TLV_TC_IT0] && !ext_request_pin0 |=> tctl_q[TLV_TC_IE0])
    else $error("low level did not set external flag");

  a_edge_clear: assert property (
    take && src_q == TLV_SRC_EXT0 && tctl_q[TLV_TC_IT0] && !ext_set[0]
      && !sfr_wr && !bit_wr |=> !tctl_q[TLV_TC_IE0])
    else $error("edge flag not cleared on service");

  a_timer_clear: assert property (
    take && src_q == TLV_SRC_TMR1 && !timer1_rollover && !sfr_wr && !bit_wr
      |=> !tctl_q[TLV_TC_TF1])
    else $error("timer flag not cleared on service");

  a_t2_hold: assert property (
    take && src_q == TLV_SRC_TMR2 && !sfr_wr && !bit_wr
      |=> (t2_q & $past(t2_q)) == $past(t2_q))
    else $error("timer 2 flag cleared by service");

  a_accept_seq: assert property (
    take && !return_from_interrupt |=> !irq_req && (in_service_hi || in_service_lo)
      ##1 !irq_req)
    else $error("accept did not mark in-service");

  a_return_clear: assert property (
    return_from_interrupt && !take && ins_hi_q |=> !ins_hi_q)
    else $error("return did not clear high level");

  a_reset_enable: assert property (disable iff (1'b0) !rst_b |=> ien_q == TLV_IEN_RST)
    else $error("enable register not cleared by reset");

  a_bit_write: assert property (
    bit_wr && !sfr_wr && bit_addr[7:3] == TLV_ADDR_IEN[7:3]
      |=> ((ien_q ^ $past(ien_q)) & ~(8'h01 << $past(bit_addr[2:0]))) == 8'h00)
    else $error("bit write disturbed other bits");

  a_same_level_wait: assert property (
    ins_lo_q && !ins_hi_q && irq_req |-> src_hi_q)
    else $error("same level request offered during service");
endmodule

// ---- rtl/tlv_pkg.sv ----
// Constants shared by the vectored interrupt unit files
package tlv_pkg;
  localparam int TLV_NSRC = 6;

  // Register addresses on the special-function register port
  localparam logic [7:0] TLV_ADDR_TCTL = 8'h88;
  localparam logic [7:0] TLV_ADDR_SER = 8'h98;
  localparam logic [7:0] TLV_ADDR_IEN = 8'hA8;
  localparam logic [7:0] TLV_ADDR_PRIO = 8'hB8;
  localparam logic [7:0] TLV_ADDR_T2 = 8'hC8;

  // Reset values and implemented-bit masks
  localparam logic [7:0] TLV_IEN_RST = 8'h00;
  localparam logic [7:0] TLV_PRIO_RST = 8'h00;
  localparam logic [7:0] TLV_TCTL_RST = 8'h00;
  localparam logic [7:0] TLV_IEN_MASK = 8'hBF;
  localparam logic [7:0] TLV_PRIO_MASK = 8'h3F;
  localparam logic [7:0] TLV_TCTL_MASK = 8'hAF;
  localparam logic [7:0] TLV_SER_MASK = 8'h03;
  localparam logic [7:0] TLV_T2_MASK = 8'hC0;

  // Field positions
  localparam int TLV_IEN_GLOBAL = 7;
  localparam int TLV_TC_TF1 = 7;
  localparam int TLV_TC_TF0 = 5;
  localparam int TLV_TC_IE1 = 3;
  localparam int TLV_TC_IT1 = 2;
  localparam int TLV_TC_IE0 = 1;
  localparam int TLV_TC_IT0 = 0;
  localparam int TLV_SER_TX = 1;
  localparam int TLV_SER_RX = 0;
  localparam int TLV_T2_TF = 7;
  localparam int TLV_T2_EXF = 6;

  // Source index, natural order, lowest index ranks first
  localparam logic [2:0] TLV_SRC_EXT0 = 3'h0;
  localparam logic [2:0] TLV_SRC_TMR0 = 3'h1;
  localparam logic [2:0] TLV_SRC_EXT1 = 3'h2;
  localparam logic [2:0] TLV_SRC_TMR1 = 3'h3;
  localparam logic [2:0] TLV_SRC_SER = 3'h4;
  localparam logic [2:0] TLV_SRC_TMR2 = 3'h5;

  // Vector map: reset, then first source vector and stride
  localparam logic [15:0] TLV_VEC_RESET = 16'h0000;
  localparam logic [15:0] TLV_VEC_FIRST = 16'h0003;
  localparam logic [15:0] TLV_VEC_STRIDE = 16'h0008;

  // Least high-plus-low time on an edge pin, in oscillator periods
  localparam int TLV_EXT_MIN_OSC = 12;

  typedef enum logic [1:0] {
    TLV_ST_IDLE = 2'b00,
    TLV_ST_REQ = 2'b01,
    TLV_ST_TAKEN = 2'b10
  } tlv_state_e;
endpackage

// ---- rtl/tlv_ext_detect.sv ----
// External request pin detector, edge or level
`timescale 1ns/100ps
module tlv_ext_detect (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pin and mode
  input wire logic pin,
  input wire logic edge_select,
  // Request set strobe
  output logic set
);
  logic pin_q;
  logic pin_d;

  // Idle high, so a pin already low at reset release is taken as a falling edge
  always_comb begin
    pin_d = pin;
    if (edge_select) begin
      set = pin_q & ~pin;
    end else begin
      set = ~pin;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

  a_edge_detect: assert property (@(posedge core_clk) disable iff (!rst_b)
    edge_select && pin ##1 edge_select && !pin |-> set)
    else $error("falling edge on request pin not detected");
endmodule

// ---- rtl/tlv_prio_arb.sv ----
// Two-level priority arbiter over the gated requests
`timescale 1ns/100ps
module tlv_prio_arb #(
  parameter int NSRC = 6
) (
  // Gated requests and priority bits
  input wire logic [NSRC-1:0] pend,
  input wire logic [NSRC-1:0] prio,
  // Levels now in service
  input wire logic ins_hi,
  input wire logic ins_lo,
  // Winner
  output logic sel_valid,
  output logic [2:0] sel_idx,
  output logic sel_hi
);
  logic [NSRC-1:0] hi_pend;
  logic [NSRC-1:0] lo_pend;
  logic [2:0] hi_idx;
  logic [2:0] lo_idx;

  // Scan from the top so the lowest index wins within a level
  always_comb begin
    hi_pend = pend & prio;
    lo_pend = pend & ~prio;
    hi_idx = 3'h0;
    lo_idx = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (hi_pend[i]) begin
        hi_idx = 3'(i);
      end
      if (lo_pend[i]) begin
        lo_idx = 3'(i);
      end
    end
    // High level preempts low service; same level waits for return
    if (|hi_pend && !ins_hi) begin
      sel_valid = 1'b1;
      sel_idx = hi_idx;
      sel_hi = 1'b1;
    end else if (|lo_pend && !ins_hi && !ins_lo) begin
      sel_valid = 1'b1;
      sel_idx = lo_idx;
      sel_hi = 1'b0;
    end else begin
      sel_valid = 1'b0;
      sel_idx = 3'h0;
      sel_hi = 1'b0;
    end
  end
endmodule

// ---- dv/tlv_core_model.sv ----
// Core-side model that accepts offered vectors after a chosen wait
`timescale 1ns/100ps
module tlv_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Offer from the unit
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  // Behaviour controls
  input wire logic accept_en,
  input wire logic [3:0] wait_cycles,
  // Acknowledge and record of taken vectors
  output logic irq_ack,
  output logic [15:0] taken_vector,
  output logic [7:0] n_taken
);
  logic [3:0] cnt_q;

  // Ack held until sampled with the offer still up, then dropped
  always @(posedge core_clk) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      taken_vector <= 16'h0000;
      n_taken <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      if (irq_ack && irq_req) begin
        taken_vector <= irq_vector;
        n_taken <= n_taken + 8'h01;
      end
      if (irq_ack) begin
        irq_ack <= irq_req ? 1'b0 : 1'b1;
      end else if (accept_en && irq_req) begin
        if (cnt_q == wait_cycles) begin
          irq_ack <= 1'b1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

// ---- dv/tb_tlv_irq_unit.sv ----
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_tlv_irq_unit
  import tlv_pkg::*;
;
  logic core_clk, rst_b, sfr_wr, bit_wr, bit_wdata, pin0, pin1, mode3, ret, accept_en;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, sfr_rdata, n_taken;
  logic [5:0] ev;
  logic irq_ack, irq_req, in_service_hi, in_service_lo;
  logic [15:0] irq_vector, taken_vector;
  int n_errors, checked;

  tlv_irq_unit uut (.core_clk(core_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
    .sfr_rdata(sfr_rdata), .ext_request_pin0(pin0), .ext_request_pin1(pin1),
    .timer0_rollover(ev[0]), .timer0_mode3(mode3), .timer1_rollover(ev[1]),
    .timer2_rollover(ev[2]), .timer2_trigger(ev[3]), .serial_rx_done(ev[4]),
    .serial_tx_done(ev[5]), .irq_ack(irq_ack), .return_from_interrupt(ret),
    .irq_req(irq_req), .irq_vector(irq_vector), .in_service_hi(in_service_hi),
    .in_service_lo(in_service_lo));

  tlv_core_model core (.core_clk(core_clk), .rst_b(rst_b), .irq_req(irq_req),
    .irq_vector(irq_vector),
    .accept_en(accept_en), .wait_cycles(4'h2), .irq_ack(irq_ack),
    .taken_vector(taken_vector), .n_taken(n_taken));

  always #50 core_clk = ~core_clk;

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick;
    // Idle edge so a following write never re-raises the strobe at once
    sfr_wr = 1'b0;
    tick;
  endtask

  task automatic bwr(input logic [7:0] a, input logic d);
    bit_addr = a;
    bit_wdata = d;
    bit_wr = 1'b1;
    tick;
    bit_wr = 1'b0;
    tick;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    tick;
    `CHK("sfr_rdata", exp, sfr_rdata)
  endtask

  task automatic fire(input logic [5:0] e, input logic p0, input logic p1);
    ev = e;
    pin0 = p0;
    pin1 = p1;
    tick;
    ev = 6'h00;
    pin0 = 1'b1;
    pin1 = 1'b1;
    tick;
  endtask

  // Offer taken by the core model, then vector and level judged
  task automatic serve(input logic [15:0] vec, input logic hi);
    logic [7:0] n0;
    n0 = n_taken;
    accept_en = 1'b1;
    for (int i = 0; i < 20 && n_taken == n0; i++) tick;
    accept_en = 1'b0;
    `CHK("taken", n0 + 8'h01, n_taken)
    `CHK("vector", vec, taken_vector)
    `CHK("in_service", 1'b1, hi ? in_service_hi : in_service_lo)
  endtask

  task automatic rti;
    ret = 1'b1;
    tick;
    ret = 1'b0;
    tick;
  endtask

  task automatic t_regs;
    rd_chk(TLV_ADDR_IEN, 8'h00);
    rd_chk(TLV_ADDR_PRIO, 8'h00);
    rd_chk(8'h90, 8'h00);
    wr(TLV_ADDR_IEN, 8'hFF);
    rd_chk(TLV_ADDR_IEN, 8'hBF);
    bwr(TLV_ADDR_IEN, 1'b0);
    rd_chk(TLV_ADDR_IEN, 8'hBE);
    wr(TLV_ADDR_PRIO, 8'hFF);
    rd_chk(TLV_ADDR_PRIO, 8'h3F);
    wr(TLV_ADDR_PRIO, 8'h00);
    wr(TLV_ADDR_IEN, 8'h00);
  endtask

  task automatic t_global;
    wr(TLV_ADDR_IEN, 8'h3F);
    fire(6'h01, 1'b1, 1'b1);
    repeat (4) tick;
    `CHK("irq_req", 1'b0, irq_req)
    bwr(TLV_ADDR_IEN + 8'h07, 1'b1);
    rd_chk(TLV_ADDR_IEN, 8'hBF);
    serve(16'h000B, 1'b0);
    rti;
  endtask

  // All six sources at once, all low level, served one at a time in natural order
  task automatic t_order;
    logic [15:0] vecs [6];
    vecs = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
    wr(TLV_ADDR_TCTL, 8'h05);
    wr(TLV_ADDR_IEN, 8'hBF);
    fire(6'h3F, 1'b0, 1'b0);
    rd_chk(TLV_ADDR_TCTL, 8'hAF);
    for (int k = 0; k < 6; k++) begin
      serve(vecs[k], 1'b0);
      if (k == 3) rd_chk(TLV_ADDR_TCTL, 8'h05);
      if (k == 4) begin
        rd_chk(TLV_ADDR_SER, 8'h03);
        wr(TLV_ADDR_SER, 8'h00);
      end
      if (k == 5) begin
        rd_chk(TLV_ADDR_T2, 8'hC0);
        wr(TLV_ADDR_T2, 8'h00);
      end
      rti;
    end
    `CHK("irq_req", 1'b0, irq_req)
  endtask

  task automatic t_level;
    wr(TLV_ADDR_TCTL, 8'h00);
    wr(TLV_ADDR_IEN, 8'h81);
    pin0 = 1'b0;
    serve(16'h0003, 1'b0);
    rd_chk(TLV_ADDR_TCTL, 8'h02);
    pin0 = 1'b1;
    wr(TLV_ADDR_TCTL, 8'h00);
    rd_chk(TLV_ADDR_TCTL, 8'h00);
    rti;
    mode3 = 1'b1;
    fire(6'h01, 1'b1, 1'b1);
    rd_chk(TLV_ADDR_TCTL, 8'h00);
    mode3 = 1'b0;
    wr(TLV_ADDR_IEN, 8'h88);
    wr(TLV_ADDR_TCTL, 8'h80);
    serve(16'h001B, 1'b0);
    rti;
  endtask

  // Raised level first when simultaneous, then preemption of a low routine
  task automatic t_prio;
    wr(TLV_ADDR_IEN, 8'hA1);
    wr(TLV_ADDR_PRIO, 8'h20);
    wr(TLV_ADDR_TCTL, 8'h01);
    fire(6'h04, 1'b0, 1'b1);
    serve(16'h002B, 1'b1);
    wr(TLV_ADDR_T2, 8'h00);
    rti;
    serve(16'h0003, 1'b0);
    fire(6'h08, 1'b1, 1'b1);
    serve(16'h002B, 1'b1);
    `CHK("in_service_lo", 1'b1, in_service_lo)
    wr(TLV_ADDR_T2, 8'h00);
    rti;
    `CHK("in_service_hi", 1'b0, in_service_hi)
    `CHK("in_service_lo", 1'b1, in_service_lo)
    rti;
    `CHK("in_service_lo", 1'b0, in_service_lo)
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    wrap_up;
  end

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    {sfr_wr, bit_wr, bit_wdata, mode3, ret, accept_en} = 6'h00;
    {pin0, pin1} = 2'b11;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    bit_addr = 8'h00;
    ev = 6'h00;
    n_errors = 0;
    checked = 0;
    repeat (8) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    t_regs;
    t_global;
    t_order;
    t_level;
    t_prio;
    wrap_up;
  end
endmodule
